// [src/usb_irq_pkg.sv]
// Shared constants, carriers and decode helpers for the USB interrupt flag block
package usb_irq_pkg;

  // ==========================================================
  // Widths
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned ADDR_W  = 4;
  localparam int unsigned BE_W    = 4;
  localparam int unsigned FLAG_W  = 8;
  localparam int unsigned TIMER_W = 17;

  typedef logic [DATA_W-1:0] word_t;
  typedef logic [FLAG_W-1:0] flags_t;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_ERR_EN = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'hC;

  localparam logic [BE_W-1:0] BE_FULL   = 4'hF;
  localparam int unsigned     BE_LOW    = 0;
  localparam flags_t          FLAGS_RST = 8'h00;
  localparam flags_t          ALL_FLAGS = 8'hFF;
  localparam flags_t          NO_FLAGS  = 8'h00;
  localparam word_t           WORD_ZERO = 32'h00000000;

  // Flag / enable bit positions
  localparam int unsigned BIT_STALL  = 7;
  localparam int unsigned BIT_ATTACH = 6;
  localparam int unsigned BIT_RESUME = 5;
  localparam int unsigned BIT_IDLE   = 4;
  localparam int unsigned BIT_TOKEN  = 3;
  localparam int unsigned BIT_SOF    = 2;
  localparam int unsigned BIT_ERR    = 1;
  localparam int unsigned BIT_RESET  = 0;

  // Device view hides the attach position
  localparam flags_t DEV_MASK    = 8'hBF;
  // Error enable: bit 6 unimplemented
  localparam flags_t ERR_EN_MASK = 8'hBF;

  // Control register bits
  localparam int unsigned CTRL_HOST   = 0;
  localparam int unsigned CTRL_LOWSPD = 1;

  // ==========================================================
  // Timing at 20 MHz
  localparam real CLK_MHZ        = 20.0;
  localparam real RESUME_TIME_US = 2.5;
  localparam real RESET_TIME_US  = 2.5;
  localparam real ATTACH_TIME_US = 2.5;
  localparam real IDLE_TIME_MS   = 3.0;

  localparam int unsigned RESUME_CYC       = int'($ceil(RESUME_TIME_US * CLK_MHZ));
  localparam int unsigned RESET_CYC        = int'($ceil(RESET_TIME_US * CLK_MHZ));
  localparam int unsigned ATTACH_CYC       = int'($ceil(ATTACH_TIME_US * CLK_MHZ));
  localparam int unsigned IDLE_CYC_DEFAULT = int'($ceil(IDLE_TIME_MS * 1000.0 * CLK_MHZ));

  localparam logic [TIMER_W-1:0] RESUME_LIMIT = TIMER_W'(RESUME_CYC);
  localparam logic [TIMER_W-1:0] RESET_LIMIT  = TIMER_W'(RESET_CYC);
  localparam logic [TIMER_W-1:0] ATTACH_LIMIT = TIMER_W'(ATTACH_CYC);

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [BE_W-1:0]   byteenable;
    word_t             writedata;
  } avmm_req_s;

  typedef struct packed {
    logic stall_sent;
    logic token_done;
    logic sof_token;
    logic sof_threshold;
    logic bus_activity;
  } usb_evt_s;

  // ==========================================================
  // Helpers
  // Line state: K is differential 1 at low speed, differential 0 at full speed
  function automatic logic line_is_k(input logic dp, input logic dm, input logic lowspd);
    line_is_k = lowspd ? (dp & ~dm) : (~dp & dm);
  endfunction : line_is_k

  function automatic logic line_is_j(input logic dp, input logic dm, input logic lowspd);
    line_is_j = lowspd ? (~dp & dm) : (dp & ~dm);
  endfunction : line_is_j

  // Software-visible flags or enables for the current mode
  function automatic flags_t mode_view(input flags_t v, input logic host);
    mode_view = host ? v : (v & DEV_MASK);
  endfunction : mode_view

endpackage : usb_irq_pkg

// [src/line_state_timer.sv]
// Persistence timer: one pulse once a condition has held for LIMIT cycles
`timescale 1ns/10ps
`default_nettype none

module line_state_timer #(
  parameter logic [usb_irq_pkg::TIMER_W-1:0] LIMIT = usb_irq_pkg::RESUME_LIMIT
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  input  wire logic cond,
  output logic      hit
);
  import usb_irq_pkg::*;

  localparam logic [TIMER_W-1:0] LAST = LIMIT - 1'b1;
  localparam logic [TIMER_W-1:0] ZERO = '0;

  logic [TIMER_W-1:0] cnt_q, cnt_d;
  logic               done_q, done_d;
  logic               hit_q, hit_d;

  // ==========================================================
  // Counter
  always_comb begin
    cnt_d  = cnt_q;
    done_d = done_q;
    hit_d  = 1'b0;
    if (!cond) begin
      cnt_d  = ZERO;
      done_d = 1'b0;
    end else if (!done_q) begin
      if (cnt_q == LAST) begin
        // Stays done until the condition drops, so one hit per hold
        done_d = 1'b1;
        hit_d  = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q  <= '0;
      done_q <= 1'b0;
      hit_q  <= 1'b0;
    end else if (clk_en) begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
      hit_q  <= hit_d;
    end
  end

  assign hit = hit_q;

  // ==========================================================
  // Checks
  property p_one_hit_per_hold;
    @(posedge core_clk) disable iff (rst)
    (hit_q && cond && clk_en) |=> !hit_q;
  endproperty
  a_one_hit_per_hold: assert property (p_one_hit_per_hold) else $error("timer hit twice in one hold");

  property p_hit_needs_cond;
    @(posedge core_clk) disable iff (rst)
    $rose(hit_q) |-> $past(cond);
  endproperty
  a_hit_needs_cond: assert property (p_hit_needs_cond) else $error("timer hit without condition");

endmodule : line_state_timer

`default_nettype wire

// [src/usb_core_interrupt_flags.sv]
// USB core interrupt status, enable and error-summary logic with Avalon-MM slave
//
// Overview of operation
// - Sent STALL handshake sets stall flag.
// - K-state held 2.5 us sets resume.
// - Idle bus for 3 ms sets idle.
// - Token done sets flag; clearing advances FIFO.
// - SOF token or host threshold sets flag.
// - Only enabled errors set summary; device read-only.
// - Device: reset after 2.5 us, once per reset.
// - Host: not SE0, quiet 2.5 us, attach.
// - Host: detach in bit 0, once per detach.
// - Flags clear by ones in full-word write.
// - Enable one passes flag; all reset zero.
// - Enable bit 0 gates reset or detach.
// - Device mode: attach enable (bit 6) reads zero.
// - Upper bits and device bit 6 zero.
// - Summary built from per-error flags.
//
// The address map and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module usb_core_interrupt_flags #(
  parameter int unsigned IDLE_CYCLES = usb_irq_pkg::IDLE_CYC_DEFAULT
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   clk_en,
  input  wire usb_irq_pkg::avmm_req_s avs_req,
  output logic [usb_irq_pkg::DATA_W-1:0] avs_readdata,
  output logic                        avs_waitrequest,
  input  wire logic                   usb_dp,
  input  wire logic                   usb_dm,
  input  wire usb_irq_pkg::usb_evt_s  usb_evt,
  input  wire usb_irq_pkg::flags_t    err_flags,
  output logic                        irq,
  output logic                        status_fifo_advance
);
  import usb_irq_pkg::*;

  // ==========================================================
  // State
  logic   host_q, host_d;
  logic   lowspd_q, lowspd_d;
  flags_t en_q, en_d;
  flags_t err_en_q, err_en_d;
  flags_t flags_q, flags_d;
  logic   wait_q, wait_d;
  word_t  rdata_q, rdata_d;
  logic   irq_q, irq_d;
  logic   adv_q, adv_d;

  // ==========================================================
  // Line decode and persistence timers
  logic se0, line_k, line_j, quiet;
  logic resume_hit, idle_hit, se0_hit, attach_hit;

  always_comb begin
    se0    = ~usb_dp & ~usb_dm;
    line_k = line_is_k(usb_dp, usb_dm, lowspd_q);
    line_j = line_is_j(usb_dp, usb_dm, lowspd_q);
    // Any activity restarts the attach wait
    quiet  = host_q & ~se0 & ~usb_evt.bus_activity;
  end

  line_state_timer #(.LIMIT(RESUME_LIMIT)) u_resume_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .cond     (line_k),
    .hit      (resume_hit)
  );

  line_state_timer #(.LIMIT(TIMER_W'(IDLE_CYCLES))) u_idle_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .cond     (line_j),
    .hit      (idle_hit)
  );

  // Shared by reset (device) and detach (host): both are a held SE0
  line_state_timer #(.LIMIT(RESET_LIMIT)) u_se0_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .cond     (se0),
    .hit      (se0_hit)
  );

  line_state_timer #(.LIMIT(ATTACH_LIMIT)) u_attach_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .cond     (quiet),
    .hit      (attach_hit)
  );

  // ==========================================================
  // Avalon-MM slave: waitrequest drops one cycle after the request
  logic   req_any, req_start, req_done;
  logic   wr_done, wr_status;
  flags_t status_view, en_view, clr, set;
  logic   err_hit;

  always_comb begin
    req_any   = avs_req.read | avs_req.write;
    req_start = req_any & wait_q;
    req_done  = req_any & ~wait_q;
    wr_done   = req_done & avs_req.write;
    wr_status = wr_done & (avs_req.address == OFS_STATUS);
    status_view = mode_view(flags_q, host_q);
    en_view     = mode_view(en_q, host_q);
  end

  always_comb begin
    wait_d  = ~req_start;
    rdata_d = rdata_q;
    if (req_start && avs_req.read) begin
      rdata_d = WORD_ZERO;
      case (avs_req.address)
        OFS_STATUS: rdata_d[FLAG_W-1:0] = status_view;
        OFS_ENABLE: rdata_d[FLAG_W-1:0] = en_view;
        OFS_ERR_EN: rdata_d[FLAG_W-1:0] = err_en_q & ERR_EN_MASK;
        OFS_CTRL: begin
          rdata_d[CTRL_HOST]   = host_q;
          rdata_d[CTRL_LOWSPD] = lowspd_q;
        end
        default: rdata_d = WORD_ZERO;
      endcase
    end
  end

  // ==========================================================
  // Writable registers
  always_comb begin
    en_d     = en_q;
    err_en_d = err_en_q;
    host_d   = host_q;
    lowspd_d = lowspd_q;
    if (wr_done && avs_req.byteenable[BE_LOW]) begin
      case (avs_req.address)
        OFS_ENABLE: en_d = avs_req.writedata[FLAG_W-1:0];
        OFS_ERR_EN: err_en_d = avs_req.writedata[FLAG_W-1:0] & ERR_EN_MASK;
        OFS_CTRL: begin
          host_d   = avs_req.writedata[CTRL_HOST];
          lowspd_d = avs_req.writedata[CTRL_LOWSPD];
        end
        default: en_d = en_q;
      endcase
    end
  end

  // ==========================================================
  // Status flags
  always_comb begin
    err_hit = |(err_flags & err_en_q & ERR_EN_MASK);
    clr = NO_FLAGS;
    if (wr_status) begin
      // A partial write behaves like a bit operation: every set flag clears
      clr = (avs_req.byteenable == BE_FULL) ? avs_req.writedata[FLAG_W-1:0] : ALL_FLAGS;
    end
    set             = NO_FLAGS;
    set[BIT_STALL]  = usb_evt.stall_sent;
    set[BIT_ATTACH] = host_q & attach_hit;
    set[BIT_RESUME] = resume_hit;
    set[BIT_IDLE]   = idle_hit;
    set[BIT_TOKEN]  = usb_evt.token_done;
    set[BIT_SOF]    = host_q ? usb_evt.sof_threshold : usb_evt.sof_token;
    set[BIT_ERR]    = err_hit;
    set[BIT_RESET]  = se0_hit;
    // Set wins over a clear in the same cycle
    flags_d = (flags_q & ~clr) | set;
    if (!host_q) begin
      flags_d[BIT_ERR]    = err_hit;
      flags_d[BIT_ATTACH] = 1'b0;
    end
    adv_d = clr[BIT_TOKEN] & flags_q[BIT_TOKEN];
    irq_d = |(status_view & en_view);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      host_q   <= 1'b0;
      lowspd_q <= 1'b0;
      en_q     <= FLAGS_RST;
      err_en_q <= FLAGS_RST;
      flags_q  <= FLAGS_RST;
      wait_q   <= 1'b1;
      rdata_q  <= WORD_ZERO;
      irq_q    <= 1'b0;
      adv_q    <= 1'b0;
    end else if (clk_en) begin
      host_q   <= host_d;
      lowspd_q <= lowspd_d;
      en_q     <= en_d;
      err_en_q <= err_en_d;
      flags_q  <= flags_d;
      wait_q   <= wait_d;
      rdata_q  <= rdata_d;
      irq_q    <= irq_d;
      adv_q    <= adv_d;
    end
  end

  assign avs_readdata        = rdata_q;
  assign avs_waitrequest     = wait_q;
  assign irq                 = irq_q;
  assign status_fifo_advance = adv_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Run lengths of line conditions, for the timing checks only
  int unsigned k_run, j_run, se0_run, quiet_run;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      k_run     <= 0;
      j_run     <= 0;
      se0_run   <= 0;
      quiet_run <= 0;
    end else if (clk_en) begin
      k_run     <= line_k ? k_run + 1 : 0;
      j_run     <= line_j ? j_run + 1 : 0;
      se0_run   <= se0 ? se0_run + 1 : 0;
      quiet_run <= quiet ? quiet_run + 1 : 0;
    end
  end

  sequence s_status_full_clear;
    clk_en && wr_status && (avs_req.byteenable == BE_FULL);
  endsequence

  sequence s_read_done;
    !wait_q && avs_req.read;
  endsequence

  property p_stall_set;
    (clk_en && usb_evt.stall_sent) |=> flags_q[BIT_STALL];
  endproperty
  a_stall_set: assert property (p_stall_set) else $error("stall flag not set");

  property p_resume_time;
    $rose(flags_q[BIT_RESUME]) |-> $past(k_run) >= RESUME_CYC;
  endproperty
  a_resume_time: assert property (p_resume_time) else $error("resume flag too early");

  property p_idle_time;
    $rose(flags_q[BIT_IDLE]) |-> $past(j_run) >= IDLE_CYCLES;
  endproperty
  a_idle_time: assert property (p_idle_time) else $error("idle flag too early");

  property p_token_advance;
    (s_status_full_clear and (flags_q[BIT_TOKEN] && avs_req.writedata[BIT_TOKEN])) |=> adv_q ##1 !adv_q;
  endproperty
  a_token_advance: assert property (p_token_advance) else $error("status FIFO did not advance");

  property p_sof_mode;
    (clk_en && !flags_q[BIT_SOF] && !host_q && usb_evt.sof_threshold && !usb_evt.sof_token) |=> !flags_q[BIT_SOF];
  endproperty
  a_sof_mode: assert property (p_sof_mode) else $error("host SOF source set device flag");

  property p_err_device;
    (clk_en && !host_q) |=> flags_q[BIT_ERR] == $past(err_hit);
  endproperty
  a_err_device: assert property (p_err_device) else $error("error summary does not track sources");

  property p_reset_time;
    $rose(flags_q[BIT_RESET]) |-> $past(se0_run) >= RESET_CYC;
  endproperty
  a_reset_time: assert property (p_reset_time) else $error("reset or detach flag too early");

  property p_attach_time;
    $rose(flags_q[BIT_ATTACH]) |-> $past(quiet_run) >= ATTACH_CYC && $past(host_q);
  endproperty
  a_attach_time: assert property (p_attach_time) else $error("attach flag too early");

  property p_w1c;
    (s_status_full_clear and (flags_q[BIT_STALL] && avs_req.writedata[BIT_STALL] && !usb_evt.stall_sent))
      |=> !flags_q[BIT_STALL];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write of one did not clear flag");

  property p_masked;
    (en_q == NO_FLAGS) [*2] |-> !irq_q;
  endproperty
  a_masked: assert property (p_masked) else $error("interrupt with all sources masked");

  property p_bit0_gate;
    (clk_en && status_view[BIT_RESET] && !en_q[BIT_RESET]
      && ((status_view & en_view) >> (BIT_RESET + 1)) == NO_FLAGS) |=> !irq_q;
  endproperty
  a_bit0_gate: assert property (p_bit0_gate) else $error("bit 0 not gated by its enable");

  property p_dev_enable_read;
    (s_read_done and (avs_req.address == OFS_ENABLE && !host_q)) |-> !avs_readdata[BIT_ATTACH];
  endproperty
  a_dev_enable_read: assert property (p_dev_enable_read) else $error("attach enable visible in device mode");

  property p_upper_zero;
    s_read_done |-> avs_readdata[DATA_W-1:FLAG_W] == '0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");

  property p_irq_raise;
    (clk_en && |(status_view & en_view)) |=> irq_q;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("interrupt not raised");

endmodule : usb_core_interrupt_flags

`default_nettype wire

// [sim/usb_peer.sv]
// Bus-side peer model: line levels and one-cycle event pulses
`timescale 1ns/10ps
`default_nettype none

module usb_peer (
  input  wire logic                  core_clk,
  output var  logic                  usb_dp,
  output var  logic                  usb_dm,
  output var  usb_irq_pkg::usb_evt_s usb_evt
);
  import usb_irq_pkg::*;

  // Low-speed attach moves the pull-up to the minus line
  logic ls = 1'b0;

  initial begin
    usb_dp  = 1'b1;
    usb_dm  = 1'b0;
    usb_evt = '0;
  end

  // ==========================================================
  // Hold a state, then fall back to the pulled-up idle level
  task automatic line(input logic dp, input logic dm, input int n);
    usb_dp <= dp;
    usb_dm <= dm;
    repeat (n) @(posedge core_clk);
    usb_dp <= ~ls;
    usb_dm <= ls;
  endtask : line

  // Events are single-cycle strobes, never held
  task automatic pulse(input usb_evt_s e);
    usb_evt <= e;
    @(posedge core_clk);
    usb_evt <= '0;
  endtask : pulse
endmodule : usb_peer
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench for the USB interrupt flag block
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module tb;
  import usb_irq_pkg::*;
  localparam int unsigned IDLE_N = 200;
  localparam int unsigned TMO    = 20000;
  localparam word_t       ALL    = 32'hFFFFFFFF;
  localparam word_t       NI     = 32'hFFFFFFEF;

  logic      core_clk;
  logic      rst;
  logic      cen;
  avmm_req_s req;
  word_t     rdata;
  word_t     rd;
  logic      wait_rq;
  logic      irq;
  logic      adv;
  usb_evt_s  evt;
  flags_t    err;
  logic      dp;
  logic      dm;
  int        error_cnt = 0;
  int        n_compared = 0;
  int        adv_cnt = 0;
  int        cyc = 0;
  int        a0;

  usb_core_interrupt_flags #(.IDLE_CYCLES(IDLE_N)) DUT (
    .core_clk(core_clk), .rst(rst), .clk_en(cen), .avs_req(req), .avs_readdata(rdata),
    .avs_waitrequest(wait_rq), .usb_dp(dp), .usb_dm(dm), .usb_evt(evt), .err_flags(err),
    .irq(irq), .status_fifo_advance(adv));
  usb_peer peer (.core_clk(core_clk), .usb_dp(dp), .usb_dm(dm), .usb_evt(evt));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic report_and_stop;
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  // Cycle ceiling doubles as the fifo-advance pulse counter
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (adv === 1'b1) adv_cnt <= adv_cnt + 1;
    if (cyc == TMO) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ==========================================================
  // Avalon master: request held until the rising edge that samples waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input word_t d, input logic [3:0] be);
    @(posedge core_clk);
    req <= '{read: ~w, write: w, address: a, byteenable: be, writedata: d};
    do begin
      @(posedge core_clk);
    end while (wait_rq !== 1'b0);
    rd = rdata;
    req <= '0;
  endtask : bus

  task automatic wr(input logic [3:0] a, input word_t d);
    bus(1'b1, a, d, BE_FULL);
  endtask : wr

  task automatic chk_rd(input logic [3:0] a, input word_t m, input word_t e);
    bus(1'b0, a, WORD_ZERO, BE_FULL);
    `CHK(rd & m, e)
  endtask : chk_rd

  // Irq trails a register change by one edge
  task automatic chk_irq(input logic e);
    @(posedge core_clk);
    @(negedge core_clk);
    `CHK(irq, e)
    @(posedge core_clk);
  endtask : chk_irq

  task automatic seterr(input flags_t v);
    err <= v;
    repeat (2) @(posedge core_clk);
  endtask : seterr

  // Line goes to the new idle level first so the speed switch sees no stray K
  task automatic mode(input logic h, input logic l);
    peer.ls = l;
    peer.line(~l, l, 1);
    wr(OFS_CTRL, {30'h0, l, h});
    wr(OFS_STATUS, 32'hFF);
  endtask : mode

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    chk_rd(OFS_ENABLE, ALL, WORD_ZERO);
    chk_rd(OFS_ERR_EN, ALL, WORD_ZERO);
    chk_rd(OFS_STATUS, NI, WORD_ZERO);
    wr(4'h1, ALL);
    chk_rd(4'h1, ALL, WORD_ZERO);
    chk_irq(1'b0);
  endtask : t_reset

  task automatic t_events;
    cen <= 1'b0;
    peer.pulse('{stall_sent: 1'b1, default: 1'b0});
    cen <= 1'b1;
    chk_rd(OFS_STATUS, 32'h80, WORD_ZERO);
    wr(OFS_ENABLE, 32'h84);
    peer.pulse('{stall_sent: 1'b1, token_done: 1'b1, sof_token: 1'b1, default: 1'b0});
    chk_rd(OFS_STATUS, NI, 32'h8C);
    chk_irq(1'b1);
    wr(OFS_ENABLE, 32'h40);
    chk_irq(1'b0);
    wr(OFS_ENABLE, 32'h84);
    a0 = adv_cnt;
    wr(OFS_STATUS, 32'h88);
    chk_rd(OFS_STATUS, NI, 32'h04);
    `CHK(adv_cnt, a0 + 1)
    chk_irq(1'b1);
    bus(1'b1, OFS_STATUS, WORD_ZERO, 4'h1);
    chk_rd(OFS_STATUS, NI, WORD_ZERO);
    peer.pulse('{sof_threshold: 1'b1, default: 1'b0});
    chk_rd(OFS_STATUS, 32'h04, WORD_ZERO);
    chk_irq(1'b0);
    bus(1'b1, OFS_ENABLE, ALL, 4'hE);
    chk_rd(OFS_ENABLE, ALL, 32'h84);
  endtask : t_events

  task automatic t_resume;
    for (int s = 0; s < 2; s++) begin
      mode(1'b0, s[0]);
      peer.line(s[0], ~s[0], 40);
      chk_rd(OFS_STATUS, 32'h20, WORD_ZERO);
      peer.line(s[0], ~s[0], 56);
      chk_rd(OFS_STATUS, 32'h20, 32'h20);
    end
    mode(1'b0, 1'b0);
  endtask : t_resume

  task automatic t_idle;
    peer.line(1'b1, 1'b1, 5);
    wr(OFS_STATUS, ALL);
    repeat (IDLE_N - 20) @(posedge core_clk);
    chk_rd(OFS_STATUS, 32'h10, WORD_ZERO);
    repeat (25) @(posedge core_clk);
    chk_rd(OFS_STATUS, 32'h10, 32'h10);
  endtask : t_idle

  task automatic t_bus_reset;
    wr(OFS_ENABLE, 32'h01);
    fork
      peer.line(1'b0, 1'b0, 200);
      begin
        repeat (60) @(posedge core_clk);
        chk_rd(OFS_STATUS, 32'h01, 32'h01);
        chk_irq(1'b1);
        wr(OFS_STATUS, 32'h01);
        repeat (60) @(posedge core_clk);
        chk_rd(OFS_STATUS, 32'h01, WORD_ZERO);
      end
    join
    // One J edge ends the reset so the timer rearms
    @(posedge core_clk);
    peer.line(1'b0, 1'b0, 60);
    chk_rd(OFS_STATUS, 32'h01, 32'h01);
    wr(OFS_ENABLE, WORD_ZERO);
    chk_irq(1'b0);
  endtask : t_bus_reset

  task automatic t_errors;
    wr(OFS_ERR_EN, ALL);
    chk_rd(OFS_ERR_EN, ALL, 32'hBF);
    for (int i = 0; i < 8; i++) begin
      seterr(8'h01 << i);
      chk_rd(OFS_STATUS, 32'h02, (i == 6) ? WORD_ZERO : 32'h02);
    end
    wr(OFS_ERR_EN, 32'h01);
    seterr(8'hFE);
    chk_rd(OFS_STATUS, 32'h02, WORD_ZERO);
    seterr(8'h01);
    wr(OFS_STATUS, 32'h02);
    chk_rd(OFS_STATUS, 32'h02, 32'h02);
    seterr(8'h00);
    chk_rd(OFS_STATUS, 32'h02, WORD_ZERO);
  endtask : t_errors

  task automatic t_host;
    mode(1'b1, 1'b0);
    wr(OFS_ENABLE, ALL);
    chk_rd(OFS_ENABLE, ALL, 32'hFF);
    repeat (50) @(posedge core_clk);
    chk_rd(OFS_STATUS, 32'h40, 32'h40);
    wr(OFS_STATUS, ALL);
    peer.pulse('{bus_activity: 1'b1, default: 1'b0});
    repeat (40) @(posedge core_clk);
    chk_rd(OFS_STATUS, 32'h40, WORD_ZERO);
    repeat (15) @(posedge core_clk);
    chk_rd(OFS_STATUS, 32'h40, 32'h40);
    fork
      peer.line(1'b0, 1'b0, 150);
      begin
        wr(OFS_STATUS, ALL);
        wr(OFS_ENABLE, 32'h01);
        repeat (60) @(posedge core_clk);
        chk_rd(OFS_STATUS, 32'h01, 32'h01);
        chk_irq(1'b1);
        wr(OFS_STATUS, 32'h01);
        repeat (30) @(posedge core_clk);
        chk_rd(OFS_STATUS, 32'h01, WORD_ZERO);
        chk_irq(1'b0);
      end
    join
    peer.pulse('{sof_threshold: 1'b1, default: 1'b0});
    chk_rd(OFS_STATUS, 32'h04, 32'h04);
    wr(OFS_ERR_EN, 32'h01);
    seterr(8'h01);
    seterr(8'h00);
    chk_rd(OFS_STATUS, 32'h02, 32'h02);
    wr(OFS_STATUS, 32'h02);
    chk_rd(OFS_STATUS, 32'h02, WORD_ZERO);
    wr(OFS_ENABLE, ALL);
    repeat (50) @(posedge core_clk);
    wr(OFS_CTRL, WORD_ZERO);
    chk_rd(OFS_STATUS, 32'h40, WORD_ZERO);
    chk_rd(OFS_ENABLE, ALL, 32'hBF);
  endtask : t_host

  // ==========================================================
  initial begin
    rst = 1'b1;
    cen = 1'b1;
    req = '0;
    err = '0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_events();
    t_resume();
    t_idle();
    t_bus_reset();
    t_errors();
    t_host();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
